// ===== verilog/operand_memory_read_cycle.sv
// Purpose: operand read machine cycles after an opcode fetch
// Assumes: phaseClk is the processor phase clock, sampled by clk
// Notes: T states advance on phaseClk rising edges, halves on falls

// Contract
// - port target: one operand read cycle
// - memory target: two consecutive read cycles
// - one byte per cycle, low then high
// - counter advances after fetch, sequential reads
// - each read cycle is T1, T2, T3
// - late T1: address, status, cycle start
// - cycle start goes onto the bus
// - status strobe low at T2 start
// - status passes outward while buffers enabled low
// - latched memory-read status high on bus
// - data-in window late T2 to early T3
// - data path needs strobe and panel gate
// - read indicator follows memory-read status
// - port input opcode: then input read cycle
module operand_memory_read_cycle #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phaseClk,
  input wire logic [7:0] dataIn,
  input wire logic panelInputGate,
  input wire opr_pkg::fetch_t fetch,
  output opr_pkg::bus_out_t busOut,
  output logic statusLatchPulseN,
  output logic cpuDataInWindow,
  output logic inputBufferEnableN,
  output logic dataInPathOpen,
  output opr_pkg::operand_t result,
  output opr_pkg::tstate_t tState
);
  import opr_pkg::*;

  if (ADDR_W != 16 || DATA_W != 8) begin : bad_width
    $error("only a 16-bit address and 8-bit data are supported");
  end

  logic [9:0] pinSync;
  logic phiSync;
  logic gateSync;
  logic [7:0] dataSync;
  logic phiPrev;
  logic phiRise;
  logic phiFall;
  logic pending;
  logic [1:0] readsLeft;
  logic [1:0] readsTotal;
  logic [15:0] pc;
  logic [15:0] addrReg;
  logic [7:0] statusReg;
  logic [7:0] latchedStatus;
  logic cycleStart;
  logic [7:0] opcodeReg;
  logic [15:0] operandReg;
  logic valid;
  logic inputReq;
  logic lastRead;
  logic cycleEnd;
  logic highByte;

  // data lines are stable around the window, so a plain sync is enough
  sync_2ff #(.W(10)) pins_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({phaseClk, panelInputGate, dataIn}),
    .q(pinSync)
  );
  assign phiSync = pinSync[9];
  assign gateSync = pinSync[8];
  assign dataSync = pinSync[7:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phiPrev <= 1'b0;
    end else begin
      phiPrev <= phiSync;
    end
  end
  assign phiRise = phiSync & ~phiPrev;
  assign phiFall = ~phiSync & phiPrev;
  assign lastRead = (readsLeft == PORT_READS);
  assign cycleEnd = (tState == ST_T3) && phiRise;
  assign highByte = (readsTotal == MEM_READS) && lastRead;
  // request pending: a new fetch wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else if (fetch.fetchDone && fetch.kind != OPK_NONE) begin
      pending <= 1'b1;
    end else if (tState == ST_IDLE && phiRise) begin
      pending <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readsLeft <= 2'h0;
      readsTotal <= 2'h0;
      opcodeReg <= 8'h00;
    end else if (fetch.fetchDone && fetch.kind != OPK_NONE) begin
      readsLeft <= (fetch.kind == OPK_MEM) ? MEM_READS : PORT_READS;
      readsTotal <= (fetch.kind == OPK_MEM) ? MEM_READS : PORT_READS;
      opcodeReg <= fetch.opcode;
    end else if (cycleEnd) begin
      readsLeft <= readsLeft - 2'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tState <= ST_IDLE;
    end else if (phiRise) begin
      case (tState)
        ST_IDLE: begin
          if (pending) begin
            tState <= ST_T1;
          end
        end
        ST_T1: begin
          tState <= ST_T2;
        end
        ST_T2: begin
          tState <= ST_T3;
        end
        ST_T3: begin
          tState <= lastRead ? ST_IDLE : ST_T1;
        end
        default: begin
          tState <= ST_IDLE;
        end
      endcase
    end
  end
  // counter steps after fetch and each read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= PC_RESET;
    end else if (fetch.fetchDone) begin
      pc <= fetch.fetchPc + ONE_LOCATION;
    end else if (cycleEnd) begin
      pc <= pc + ONE_LOCATION;
    end
  end
  // address and status out in late T1, held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrReg <= 16'h0000;
      statusReg <= STATUS_RESET;
    end else if (tState == ST_T1 && phiFall) begin
      addrReg <= pc;
      statusReg <= STATUS_MEM_READ;
    end
  end
  // cycle start from late T1 to T2 entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cycleStart <= 1'b0;
    end else if (tState == ST_T1 && phiFall) begin
      cycleStart <= 1'b1;
    end else if (tState == ST_T1 && phiRise) begin
      cycleStart <= 1'b0;
    end
  end
  // one clk low pulse on entry to T2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusLatchPulseN <= 1'b1;
    end else begin
      statusLatchPulseN <= ~(tState == ST_T1 && phiRise && cycleStart);
    end
  end
  // latch captured by the strobe, kept to cycle end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latchedStatus <= STATUS_RESET;
    end else if (!statusLatchPulseN) begin
      latchedStatus <= statusReg;
    end else if (cycleEnd) begin
      latchedStatus <= STATUS_RESET;
    end
  end
  // window opens at T2 fall, closes at T3 fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuDataInWindow <= 1'b0;
    end else if (tState == ST_T2 && phiFall) begin
      cpuDataInWindow <= 1'b1;
    end else if (tState == ST_T3 && phiFall) begin
      cpuDataInWindow <= 1'b0;
    end
  end

  assign inputBufferEnableN = cpuDataInWindow;
  // panel gate blocks data in while panel is in use
  assign dataInPathOpen = cpuDataInWindow & gateSync;
  // byte sampled as the window closes in T3
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operandReg <= 16'h0000;
    end else if (fetch.fetchDone) begin
      operandReg <= 16'h0000;
    end else if (tState == ST_T3 && phiFall && dataInPathOpen) begin
      if (highByte) begin
        operandReg[15:8] <= dataSync;
      end else begin
        operandReg[7:0] <= dataSync;
      end
    end
  end
  // port input opcode asks for the input read next
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid <= 1'b0;
      inputReq <= 1'b0;
    end else begin
      valid <= cycleEnd && lastRead;
      inputReq <= cycleEnd && lastRead && (opcodeReg == OPC_PORT_INPUT);
    end
  end

  always_comb begin
    busOut.addr = addrReg;
    busOut.statusOut = statusReg;
    // status drives outward only while buffers point out
    busOut.statusOutEn_n = inputBufferEnableN | (tState == ST_IDLE);
    busOut.busCycleStart = cycleStart;
    busOut.memReadStatus = latchedStatus[STATUS_READ_INDICATOR_POS];
    busOut.busDataInStrobe = cpuDataInWindow;
    // indicator lit by the read status
    busOut.readIndicator = latchedStatus[STATUS_READ_INDICATOR_POS];
    result.valid = valid;
    result.operand = operandReg;
    result.nextPc = pc;
    result.inputReq = inputReq;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  port_count_a: assert property (
    fetch.fetchDone && fetch.kind == OPK_PORT |=> readsLeft == PORT_READS)
    else $error("port target did not load one read");
  mem_count_a: assert property (
    fetch.fetchDone && fetch.kind == OPK_MEM |=> readsLeft == MEM_READS)
    else $error("memory target did not load two reads");
  pc_step_a: assert property (
    fetch.fetchDone |=> pc == $past(fetch.fetchPc) + ONE_LOCATION)
    else $error("counter not advanced after fetch");
  three_states_a: assert property (
    cycleEnd && !lastRead |=> tState == ST_T1)
    else $error("second read did not restart at T1");
  start_in_t1_a: assert property (
    busOut.busCycleStart |-> tState == ST_T1 && statusReg == STATUS_MEM_READ)
    else $error("cycle start outside T1");
  strobe_t2_a: assert property (
    $fell(statusLatchPulseN) |-> tState == ST_T2 && $past(cycleStart))
    else $error("status strobe not at T2 start");
  status_out_a: assert property (
    !statusLatchPulseN |-> !busOut.statusOutEn_n)
    else $error("status not driven outward at the strobe");
  read_status_a: assert property (
    !statusLatchPulseN |=> busOut.memReadStatus)
    else $error("memory-read status not latched");
  window_t2t3_a: assert property (
    $rose(cpuDataInWindow) |-> tState == ST_T2 && busOut.busDataInStrobe)
    else $error("data-in window outside late T2");
  path_gate_a: assert property (
    dataInPathOpen |-> busOut.busDataInStrobe && gateSync)
    else $error("data path open without strobe and gate");
  indicator_a: assert property (
    busOut.readIndicator == busOut.memReadStatus)
    else $error("read indicator differs from read status");
  input_next_a: assert property (
    result.inputReq |-> result.valid && opcodeReg == OPC_PORT_INPUT)
    else $error("input read asked for a wrong opcode");
  addr_hold_a: assert property (
    tState == ST_T2 || (tState == ST_T3 && !phiRise) |=> $stable(busOut.addr))
    else $error("address moved inside the cycle");

  port_read_c: cover property (
    result.valid && result.inputReq);
  mem_read_c: cover property (
    result.valid && readsTotal == MEM_READS);
  panel_block_c: cover property (
    cpuDataInWindow && !gateSync);

endmodule

// ===== verilog/opr_pkg.sv
// Purpose: shared types and constants for the operand read sequencer
// Assumes: 16-bit address bus, 8-bit data, one status byte per cycle
// Notes: status byte carries only the memory-read flag
package opr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_T1 = 2'b01,
    ST_T2 = 2'b10,
    ST_T3 = 2'b11
  } tstate_t;

  typedef enum logic [1:0] {
    OPK_NONE = 2'b00,
    OPK_PORT = 2'b01,
    OPK_MEM = 2'b10
  } opkind_t;

  localparam logic [7:0] OPC_PORT_INPUT = 8'hDB;
  localparam logic [7:0] STATUS_MEM_READ = 8'h80;
  localparam int STATUS_READ_INDICATOR_POS = 7;
  localparam logic [1:0] PORT_READS = 2'h1;
  localparam logic [1:0] MEM_READS = 2'h2;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] ONE_LOCATION = 16'h0001;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] statusOut;
    logic statusOutEn_n;
    logic busCycleStart;
    logic memReadStatus;
    logic busDataInStrobe;
    logic readIndicator;
  } bus_out_t;

  typedef struct packed {
    logic fetchDone;
    logic [15:0] fetchPc;
    logic [7:0] opcode;
    opkind_t kind;
  } fetch_t;

  typedef struct packed {
    logic valid;
    logic [15:0] operand;
    logic [15:0] nextPc;
    logic inputReq;
  } operand_t;

endpackage

// ===== verilog/sync_2ff.sv
// Purpose: two-flop synchroniser for pins from outside the clk domain
// Assumes: each bit is a level, held long enough to be seen
// Notes: multi-bit data must be stable across its sampling window
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ===== tb/mem_card_model.sv
// Purpose: memory card answering operand reads on the bus
// Assumes: byte at an address is a fixed mix of its address bits
// Notes: released data lines toggle, so a stale byte never stays for two clk cycles
module mem_card_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire opr_pkg::bus_out_t busOut,
  output logic [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import opr_pkg::*;
  logic [15:0] lastAddr;

  function automatic logic [7:0] memByte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastAddr <= 16'h0000;
    end else if (busOut.busCycleStart) begin
      lastAddr <= busOut.addr;
    end
  end

  // byte driven while read is requested
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataIn <= 8'hFF;
    end else if (busOut.memReadStatus) begin
      dataIn <= memByte(lastAddr);
    end else begin
      dataIn <= ~dataIn;
    end
  end
endmodule

// ===== tb/operand_memory_read_cycle_tb.sv
// Purpose: self-checking bench for the operand read sequencer
// Assumes: phase clock runs free at 160 ns, unrelated to clk
// Notes: bus events are sampled on the falling clk edge
module operand_memory_read_cycle_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import opr_pkg::*;
  logic clk, rst_b, phaseClk, panelInputGate, got;
  logic [7:0] dataIn;
  fetch_t fetch;
  bus_out_t busOut;
  logic statusLatchPulseN, cpuDataInWindow, inputBufferEnableN;
  logic dataInPathOpen, prevWin;
  operand_t result, r;
  tstate_t tState;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] seen[$];

  operand_memory_read_cycle dut (.clk(clk), .rst_b(rst_b),
    .phaseClk(phaseClk), .dataIn(dataIn),
    .panelInputGate(panelInputGate), .fetch(fetch), .busOut(busOut),
    .statusLatchPulseN(statusLatchPulseN),
    .cpuDataInWindow(cpuDataInWindow),
    .inputBufferEnableN(inputBufferEnableN),
    .dataInPathOpen(dataInPathOpen), .result(result), .tState(tState));
  mem_card_model mem (.clk(clk), .rst_b(rst_b), .busOut(busOut),
    .dataIn(dataIn));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    phaseClk = 1'b0;
    #7;
    forever #80 phaseClk = ~phaseClk;
  end

  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task report_and_stop;
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang past this ceiling counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      report_and_stop();
    end
  end

  always @(negedge clk) begin
    if (rst_b && statusLatchPulseN === 1'b0) begin
      seen.push_back(busOut.addr);
      cmp("statusOut", 16'(STATUS_MEM_READ), 16'(busOut.statusOut));
      cmp("statusOutEn_n", 16'h0000, 16'(busOut.statusOutEn_n));
      cmp("strobeState", 16'(ST_T2), 16'(tState));
    end
    if (rst_b && cpuDataInWindow === 1'b1 && prevWin !== 1'b1) begin
      cmp("winState", 16'(ST_T2), 16'(tState));
      cmp("dataStrobe", 16'h0001, 16'(busOut.busDataInStrobe));
      cmp("bufInward", 16'h0001, 16'(inputBufferEnableN));
      cmp("memRead", 16'h0001, 16'(busOut.memReadStatus));
      cmp("indicator", 16'h0001, 16'(busOut.readIndicator));
      cmp("pathOpen", 16'(panelInputGate), 16'(dataInPathOpen));
      cmp("addrHeld", seen[$], busOut.addr);
    end
    prevWin = cpuDataInWindow;
  end

  task automatic do_fetch(input logic [15:0] pc, input logic [7:0] opc,
                          input opkind_t k, input int lim);
    seen.delete();
    got = 1'b0;
    @(posedge clk);
    fetch <= {1'b1, pc, opc, k};
    @(posedge clk);
    fetch.fetchDone <= 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clk);
      if (result.valid === 1'b1) begin
        got = 1'b1;
        r = result;
      end
    end
  endtask

  task automatic t_mem_operand;
    do_fetch(16'h0040, 8'h3A, OPK_MEM, 600);
    cmp("valid", 16'h0001, 16'(got));
    cmp("reads", 16'h0002, 16'(seen.size()));
    cmp("addr1", 16'h0041, seen[0]);
    cmp("addr2", 16'h0042, seen[1]);
    cmp("operand", {mem.memByte(16'h0042), mem.memByte(16'h0041)},
        r.operand);
    cmp("nextPc", 16'h0043, r.nextPc);
    cmp("inputReq", 16'h0000, 16'(r.inputReq));
  endtask

  task automatic t_port_input;
    do_fetch(16'h0100, OPC_PORT_INPUT, OPK_PORT, 600);
    cmp("valid", 16'h0001, 16'(got));
    cmp("reads", 16'h0001, 16'(seen.size()));
    cmp("addr1", 16'h0101, seen[0]);
    cmp("operand", {8'h00, mem.memByte(16'h0101)}, r.operand);
    cmp("nextPc", 16'h0102, r.nextPc);
    cmp("inputReq", 16'h0001, 16'(r.inputReq));
  endtask

  task automatic t_gate_low;
    panelInputGate <= 1'b0;
    repeat (10) @(posedge clk);
    do_fetch(16'h0200, 8'h3A, OPK_MEM, 600);
    cmp("reads", 16'h0002, 16'(seen.size()));
    cmp("operand", 16'h0000, r.operand);
    panelInputGate <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_wrap;
    do_fetch(16'hFFFE, 8'h3A, OPK_MEM, 600);
    cmp("addr1", 16'hFFFF, seen[0]);
    cmp("addr2", 16'h0000, seen[1]);
    cmp("operand", {mem.memByte(16'h0000), mem.memByte(16'hFFFF)},
        r.operand);
    cmp("nextPc", 16'h0001, r.nextPc);
  endtask

  task automatic t_no_operand;
    do_fetch(16'h0300, 8'h00, OPK_NONE, 300);
    cmp("valid", 16'h0000, 16'(got));
    cmp("reads", 16'h0000, 16'(seen.size()));
  endtask

  initial begin
    rst_b = 1'b0;
    panelInputGate = 1'b1;
    fetch = '0;
    repeat (6) @(posedge clk);
    cmp("rstStrobe", 16'h0001, 16'(statusLatchPulseN));
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_mem_operand();
    t_port_input();
    t_gate_low();
    t_wrap();
    t_no_operand();
    report_and_stop();
  end
endmodule
